// ==== pkg/pcr_pkg.sv ====
// Constants, modes and carried state of the coefficient, result and history register block
package pcr_pkg;

    localparam int unsigned PCR_CLK_MHZ = 125;

    // Byte addresses on the register bus, one aligned word each
    localparam logic [7:0] PCR_OFS_DERIV_COEF_HIGH = 8'h00;
    localparam logic [7:0] PCR_OFS_DERIV_COEF_LOW = 8'h04;
    localparam logic [7:0] PCR_OFS_RESULT_UPPER = 8'h08;
    localparam logic [7:0] PCR_OFS_RESULT_BYTE3 = 8'h0c;
    localparam logic [7:0] PCR_OFS_RESULT_BYTE2 = 8'h10;
    localparam logic [7:0] PCR_OFS_RESULT_BYTE1 = 8'h14;
    localparam logic [7:0] PCR_OFS_RESULT_BYTE0 = 8'h18;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_A_UPPER = 8'h1c;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_A_HIGH = 8'h20;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_A_LOW = 8'h24;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_B_UPPER = 8'h28;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_B_HIGH = 8'h2c;
    localparam logic [7:0] PCR_OFS_PREV_ERROR_B_LOW = 8'h30;

    // Field positions
    localparam int unsigned PCR_RESULT_W = 36;
    localparam int unsigned PCR_ERR_W = 17;
    localparam int unsigned PCR_COEF_W = 16;
    localparam int unsigned PCR_RESULT_UPPER_MSB = 35;
    localparam int unsigned PCR_RESULT_UPPER_LSB = 32;
    localparam int unsigned PCR_ERR_BIT16 = 16;

    // Values after reset
    localparam logic [15:0] PCR_RST_COEF = 16'h0000;
    localparam logic [35:0] PCR_RST_RESULT = 36'h0_0000_0000;
    localparam logic [16:0] PCR_RST_ERR = 17'h0_0000;
    localparam logic [31:0] PCR_RST_PRDATA = 32'h0000_0000;

    // Mode field: bit 1 signed operands, bit 0 accumulate
    localparam logic [2:0] PCR_MODE_PID = 3'h5;
    localparam int unsigned PCR_MODE_SIGNED_BIT = 1;
    localparam int unsigned PCR_MODE_ACCUM_BIT = 0;

    // Multiply steps of one PID iteration
    localparam logic [1:0] PCR_PID_LAST_STEP = 2'h2;

    typedef enum logic {
        PCR_IDLE,
        PCR_RUN
    } pcr_state_e;

    typedef struct packed {
        logic [15:0] deriv_coef;
        logic [35:0] result;
        logic [16:0] prev_error_a;
        logic [16:0] prev_error_b;
    } pcr_regs_s;

    typedef struct packed {
        logic [15:0] in_value;
        logic [15:0] set_value;
        logic [15:0] first_coef;
        logic [15:0] second_coef;
    } pcr_operands_s;

endpackage

// ==== design/pcr_calc.sv ====
// Multiply-accumulate sequencer that produces the result and new error histories
`timescale 1ns/1ps
module pcr_calc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic pid_en,
    input wire logic [2:0] mode,
    input wire pcr_pkg::pcr_operands_s opnd,
    input wire pcr_pkg::pcr_regs_s cur,
    output logic busy,
    output logic done,
    output pcr_pkg::pcr_regs_s upd
);
    import pcr_pkg::*;

    pcr_state_e state_reg;
    pcr_state_e state_next;
    logic [1:0] step_reg;
    logic [1:0] step_next;
    logic pid_reg;
    logic pid_next;
    logic [35:0] acc_reg;
    logic [35:0] acc_next;
    logic [16:0] err_reg;
    logic [16:0] err_next;
    logic [35:0] term;
    logic [35:0] sum;
    logic last;
    logic legal;

    // Signed 18 by 17 product, sign-extended to result width
    function automatic logic [35:0] mul(input logic signed [17:0] a,
                                        input logic signed [16:0] b);
        logic signed [34:0] p;
        p = a * b;
        return {p[34], p};
    endfunction

    function automatic logic [16:0] ext_coef(input logic [15:0] c, input logic sgn);
        return {sgn & c[15], c};
    endfunction

    // Reserved codes 100 and 11x start nothing
    assign legal = (mode == PCR_MODE_PID) || (mode[2] == 1'b0);

    always_comb begin
        logic [16:0] opsum;
        logic sgn;
        opsum = 17'h0_0000;
        sgn = mode[PCR_MODE_SIGNED_BIT];
        if (sgn) begin
            opsum = 17'({opnd.in_value[15], opnd.in_value} + {opnd.set_value[15], opnd.set_value});
        end else begin
            opsum = 17'({1'b0, opnd.in_value} + {1'b0, opnd.set_value});
        end
        term = 36'h0_0000_0000;
        if (!pid_reg) begin
            term = mul({sgn & opsum[16], opsum}, ext_coef(opnd.first_coef, sgn));
        end else begin
            unique case (step_reg)
                2'h0: term = mul({err_reg[16], err_reg}, ext_coef(opnd.first_coef, 1'b1));
                2'h1: term = mul({cur.prev_error_a[16], cur.prev_error_a},
                                 ext_coef(opnd.second_coef, 1'b1));
                default: term = mul({cur.prev_error_b[16], cur.prev_error_b},
                                    ext_coef(cur.deriv_coef, 1'b1));
            endcase
        end
    end

    assign sum = acc_reg + term;
    assign last = (state_reg == PCR_RUN) && (!pid_reg || step_reg == PCR_PID_LAST_STEP);
    assign busy = (state_reg == PCR_RUN);
    assign done = last;

    always_comb begin
        upd = cur;
        upd.result = sum;
        if (pid_reg) begin
            upd.prev_error_a = err_reg;
            upd.prev_error_b = cur.prev_error_a;
        end
    end

    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        pid_next = pid_reg;
        acc_next = acc_reg;
        err_next = err_reg;
        unique case (state_reg)
            PCR_IDLE: begin
                if (start && pid_en && legal) begin
                    state_next = PCR_RUN;
                    step_next = 2'h0;
                    pid_next = (mode == PCR_MODE_PID);
                    // PID always builds on the prior output
                    if (mode == PCR_MODE_PID || mode[PCR_MODE_ACCUM_BIT]) begin
                        acc_next = cur.result;
                    end else begin
                        acc_next = PCR_RST_RESULT;
                    end
                    err_next = 17'({opnd.in_value[15], opnd.in_value}
                                   - {opnd.set_value[15], opnd.set_value});
                end
            end
            PCR_RUN: begin
                acc_next = sum;
                step_next = 2'(step_reg + 2'h1);
                if (last) begin
                    state_next = PCR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PCR_IDLE;
            step_reg <= 2'h0;
            pid_reg <= 1'b0;
            acc_reg <= PCR_RST_RESULT;
            err_reg <= PCR_RST_ERR;
        end else if (clk_en) begin
            state_reg <= state_next;
            step_reg <= step_next;
            pid_reg <= pid_next;
            acc_reg <= acc_next;
            err_reg <= err_next;
        end
    end

endmodule

// ==== design/pcr_regs.sv ====
// APB register file for derivative coefficient, result and error histories
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pcr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pid_en,
    input wire logic [2:0] mode,
    input wire logic calc_start,
    input wire pcr_pkg::pcr_operands_s opnd,
    output logic busy
);
    import pcr_pkg::*;

    pcr_regs_s regs_reg;
    pcr_regs_s regs_next;
    pcr_regs_s upd;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic err_reg;
    logic err_next;
    logic setup;
    logic wr_en;
    logic done;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [7:0] wbyte;

    // Address to read byte; hit flags mapped addresses
    function automatic logic [8:0] read_map(input logic [7:0] addr,
                                            input pcr_regs_s r);
        logic [8:0] v;
        v = {1'b1, 8'h00};
        unique case (addr)
            PCR_OFS_DERIV_COEF_HIGH: begin
                v[7:0] = r.deriv_coef[15:8];
            end
            PCR_OFS_DERIV_COEF_LOW: begin
                v[7:0] = r.deriv_coef[7:0];
            end
            PCR_OFS_RESULT_UPPER: begin
                v[7:0] = {4'h0, r.result[35:32]};
            end
            PCR_OFS_RESULT_BYTE3: begin
                v[7:0] = r.result[31:24];
            end
            PCR_OFS_RESULT_BYTE2: begin
                v[7:0] = r.result[23:16];
            end
            PCR_OFS_RESULT_BYTE1: begin
                v[7:0] = r.result[15:8];
            end
            PCR_OFS_RESULT_BYTE0: begin
                v[7:0] = r.result[7:0];
            end
            PCR_OFS_PREV_ERROR_A_UPPER: begin
                v[7:0] = {7'h00, r.prev_error_a[16]};
            end
            PCR_OFS_PREV_ERROR_A_HIGH: begin
                v[7:0] = r.prev_error_a[15:8];
            end
            PCR_OFS_PREV_ERROR_A_LOW: begin
                v[7:0] = r.prev_error_a[7:0];
            end
            PCR_OFS_PREV_ERROR_B_UPPER: begin
                v[7:0] = {7'h00, r.prev_error_b[16]};
            end
            PCR_OFS_PREV_ERROR_B_HIGH: begin
                v[7:0] = r.prev_error_b[15:8];
            end
            PCR_OFS_PREV_ERROR_B_LOW: begin
                v[7:0] = r.prev_error_b[7:0];
            end
            default: begin
                v = 9'h000;
            end
        endcase
        return v;
    endfunction

    pcr_calc pcr_calc_inst (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .start(calc_start),
        .pid_en(pid_en),
        .mode(mode),
        .opnd(opnd),
        .cur(regs_reg),
        .busy(busy),
        .done(done),
        .upd(upd)
    );

    // Frozen clock enable stretches the access phase so no write is lost
    assign pready = clk_en;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && clk_en && pstrb[0];
    assign wbyte = pwdata[7:0];
    assign {rd_hit, rd_byte} = read_map(paddr, regs_reg);
    assign prdata = prdata_reg;
    assign pslverr = psel && penable && err_reg;

    // Read data and error are captured in the setup cycle
    always_comb begin
        prdata_next = prdata_reg;
        err_next = err_reg;
        if (setup) begin
            err_next = !rd_hit;
            prdata_next = PCR_RST_PRDATA;
            if (!pwrite) begin
                prdata_next = {24'h00_0000, rd_byte};
            end
        end
    end

    // Completion beats a software write in the same cycle
    always_comb begin
        regs_next = regs_reg;
        if (done) begin
            regs_next = upd;
        end else if (wr_en) begin
            unique case (paddr)
                PCR_OFS_DERIV_COEF_HIGH: begin
                    regs_next.deriv_coef[15:8] = wbyte;
                end
                PCR_OFS_DERIV_COEF_LOW: begin
                    regs_next.deriv_coef[7:0] = wbyte;
                end
                PCR_OFS_RESULT_UPPER: begin
                    regs_next.result[35:32] = wbyte[3:0];
                end
                PCR_OFS_RESULT_BYTE3: begin
                    regs_next.result[31:24] = wbyte;
                end
                PCR_OFS_RESULT_BYTE2: begin
                    regs_next.result[23:16] = wbyte;
                end
                PCR_OFS_RESULT_BYTE1: begin
                    regs_next.result[15:8] = wbyte;
                end
                PCR_OFS_RESULT_BYTE0: begin
                    regs_next.result[7:0] = wbyte;
                end
                PCR_OFS_PREV_ERROR_A_UPPER: begin
                    regs_next.prev_error_a[16] = wbyte[0];
                end
                PCR_OFS_PREV_ERROR_A_HIGH: begin
                    regs_next.prev_error_a[15:8] = wbyte;
                end
                PCR_OFS_PREV_ERROR_A_LOW: begin
                    regs_next.prev_error_a[7:0] = wbyte;
                end
                PCR_OFS_PREV_ERROR_B_UPPER: begin
                    regs_next.prev_error_b[16] = wbyte[0];
                end
                PCR_OFS_PREV_ERROR_B_HIGH: begin
                    regs_next.prev_error_b[15:8] = wbyte;
                end
                PCR_OFS_PREV_ERROR_B_LOW: begin
                    regs_next.prev_error_b[7:0] = wbyte;
                end
                default: begin
                    regs_next = regs_reg;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_reg.deriv_coef <= PCR_RST_COEF;
            regs_reg.result <= PCR_RST_RESULT;
            regs_reg.prev_error_a <= PCR_RST_ERR;
            regs_reg.prev_error_b <= PCR_RST_ERR;
            prdata_reg <= PCR_RST_PRDATA;
            err_reg <= 1'b0;
        end else if (clk_en) begin
            regs_reg <= regs_next;
            prdata_reg <= prdata_next;
            err_reg <= err_next;
        end
    end

endmodule

// ==== testbench/pcr_regs_monitor.sv ====
// Assertion checker for the coefficient, result and history register block
`timescale 1ns/1ps
module pcr_regs_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pid_en,
    input wire logic [2:0] mode,
    input wire logic calc_start,
    input wire pcr_pkg::pcr_operands_s opnd,
    input wire logic busy
);
    import pcr_pkg::*;

    logic go;
    logic rd_setup;
    assign go = !busy && calc_start && pid_en && clk_en;
    assign rd_setup = psel && !penable && !pwrite && clk_en;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pid_go;
        go && mode == PCR_MODE_PID;
    endsequence
    sequence s_pid_busy;
        busy [*3] ##1 !busy;
    endsequence
    a_pid_busy_span: assert property (s_pid_go |=> s_pid_busy)
        else $error("busy span wrong after pid start");
    a_mul_busy_span: assert property (go && !mode[2] |=> busy ##1 !busy)
        else $error("busy span wrong after multiply start");
    a_start_needs_en: assert property (!busy && calc_start && !pid_en |=> !busy)
        else $error("start taken while disabled");
    a_reserved_ignored: assert property (!busy && calc_start && mode[2] && mode != PCR_MODE_PID |=> !busy)
        else $error("reserved mode started");
    a_busy_has_cause: assert property ($rose(busy) |-> $past(go))
        else $error("busy rose without start");
    a_read_high_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_result_top_nibble: assert property (rd_setup && paddr == PCR_OFS_RESULT_UPPER |=> prdata[7:4] == 4'h0)
        else $error("result upper unused bits set");
    a_hist_top_bits: assert property (rd_setup && (paddr == PCR_OFS_PREV_ERROR_A_UPPER
        || paddr == PCR_OFS_PREV_ERROR_B_UPPER) |=> prdata[7:1] == 7'h0)
        else $error("history upper unused bits set");
    // First edge skipped: the reset may only take hold on it
    a_reset_clears: assert property (disable iff (1'b0) !presetn && $past(!presetn)
        |-> prdata == 32'h0 && !busy)
        else $error("outputs not clear in reset");
endmodule

// ==== testbench/pcr_regs_tb.sv ====
// Self-checking bench for the coefficient, result and history register block
`timescale 1ns/1ps
module pcr_regs_tb;
    import pcr_pkg::*;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic pid_en, calc_start, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb, strb;
    logic [2:0] mode;
    logic [35:0] v;
    logic e;
    pcr_operands_s opnd;
    int n_errors, n_tests;
    localparam logic [7:0] MSK [13] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h01, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff};
    pcr_regs pcr_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pid_en(pid_en), .mode(mode),
        .calc_start(calc_start), .opnd(opnd), .busy(busy));
    task results();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= {24'h0, d}; pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Most significant byte sits at the lowest address
    task wr_val(input logic [7:0] a, input int n, input logic [35:0] d);
        for (int k = 0; k < n; k++) apb(1'b1, 8'(a + 4 * k), 8'(d >> (8 * (n - 1 - k))));
    endtask
    task rd_val(input logic [7:0] a, input int n);
        v = '0;
        for (int k = 0; k < n; k++) begin
            apb(1'b0, 8'(a + 4 * k), 8'h00);
            v = {v[27:0], q[7:0]};
        end
    endtask
    task run(input int exp_n);
        int n;
        @(posedge pclk) calc_start <= 1'b1;
        @(posedge pclk) calc_start <= 1'b0;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("busy cycles", 36'(n), 36'(exp_n));
    endtask
    task t_reset();
        for (int i = 0; i < 13; i++) begin
            rd_val(8'(4 * i), 1);
            check("reset value", v, 36'h0);
        end
    endtask
    task t_rw();
        for (int i = 0; i < 13; i++) begin
            wr_val(8'(4 * i), 1, 36'hff);
            rd_val(8'(4 * i), 1);
            check("read back", v, {28'h0, MSK[i]});
        end
        strb = 4'h0;
        wr_val(PCR_OFS_DERIV_COEF_HIGH, 1, 36'h12);
        strb = 4'h1;
        rd_val(PCR_OFS_DERIV_COEF_HIGH, 1);
        check("strobe off", v, 36'hff);
        apb(1'b1, 8'h34, 8'h5a);
        apb(1'b0, 8'h34, 8'h00);
        check("unmapped", 36'({q[7:0], e}), 36'h001);
    endtask
    // Frozen enable stretches the access phase; the write lands once it resumes
    task t_freeze();
        clk_en <= 1'b0;
        fork
            apb(1'b1, PCR_OFS_DERIV_COEF_LOW, 8'h3c);
            begin
                repeat (4) @(posedge pclk);
                check("pready frozen", 36'(pready), 36'h0);
                clk_en <= 1'b1;
            end
        join
        rd_val(PCR_OFS_DERIV_COEF_LOW, 1);
        check("frozen write", v, 36'h3c);
    endtask
    task t_pid();
        longint res;
        int ha, hb, kp, ki, kd;
        res = 0; ha = -2; hb = 5;
        kp = 8;
        ki = -3;
        kd = -3;
        wr_val(PCR_OFS_DERIV_COEF_HIGH, 2, 36'hfffd);
        wr_val(PCR_OFS_RESULT_UPPER, 5, 36'h0);
        wr_val(PCR_OFS_PREV_ERROR_A_UPPER, 3, 36'h1fffe);
        wr_val(PCR_OFS_PREV_ERROR_B_UPPER, 3, 36'h00005);
        mode <= PCR_MODE_PID;
        opnd <= {16'h0010, 16'h0013, 16'(kp + ki + kd), 16'(-(kp + 2 * kd))};
        repeat (2) begin
            run(3);
            // Error is -3, coefficients 2, -2 and -3
            res = res - 6 - 2 * ha - 3 * hb;
            hb = ha;
            ha = -3;
            rd_val(PCR_OFS_RESULT_UPPER, 5);
            check("result", v, res[35:0]);
            rd_val(PCR_OFS_PREV_ERROR_A_UPPER, 3);
            check("prev_error_a", v, {19'h0, ha[16:0]});
            rd_val(PCR_OFS_PREV_ERROR_B_UPPER, 3);
            check("prev_error_b", v, {19'h0, hb[16:0]});
        end
    endtask
    task t_mult();
        opnd <= {16'h0001, 16'h0002, 16'h0003, 16'h0000};
        for (int m = 0; m < 4; m++) begin
            mode <= 3'(m);
            run(1);
            rd_val(PCR_OFS_RESULT_UPPER, 5);
            check("multiply result", v, m[0] ? 36'h12 : 36'h9);
        end
    endtask
    task t_refuse();
        pid_en <= 1'b0;
        mode <= PCR_MODE_PID;
        run(0);
        pid_en <= 1'b1;
        mode <= 3'h4;
        run(0);
        mode <= 3'h6;
        run(0);
        mode <= 3'h7;
        run(0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Generous span; the whole sequence needs only a few hundred cycles
    initial begin
        #200000;
        n_errors++;
        results();
    end
    initial begin
        presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; strb = 4'h1; pid_en = 1'b1;
        mode = 3'h0; calc_start = 1'b0; opnd = '0; n_errors = 0; n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rw();
        t_freeze();
        t_pid();
        t_mult();
        t_refuse();
        results();
    end
endmodule

bind pcr_regs pcr_regs_monitor pcr_regs_monitor_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pid_en(pid_en), .mode(mode), .calc_start(calc_start), .opnd(opnd), .busy(busy));
